// *** rtl/moad_pkg.sv ***
// Constants and types shared by the memory object attribute decoder.
package moad_pkg;
    // Attribute field layout.
    localparam int          MOAD_ATTR_W      = 4;
    localparam int          MOAD_BIT_DECRYPT = 3;
    localparam int          MOAD_BIT_TAG     = 2;
    localparam int          MOAD_CACHE_HI    = 1;
    localparam int          MOAD_CACHE_LO    = 0;
    // Cacheability codes.
    localparam logic [1:0]  MOAD_CACHE_TABLE = 2'h0;
    localparam logic [1:0]  MOAD_CACHE_NONE  = 2'h1;
    localparam logic [1:0]  MOAD_CACHE_LLC   = 2'h2;
    localparam logic [1:0]  MOAD_CACHE_BOTH  = 2'h3;
    // Last-level cache line tag store.
    localparam int          MOAD_IDX_W       = 4;
    localparam int          MOAD_LINES       = 16;
    localparam logic [3:0]  MOAD_LAST_LINE   = 4'hf;
    localparam logic [3:0]  MOAD_LINE_ZERO   = 4'h0;

    typedef enum logic [1:0] {
        MOAD_IDLE,
        MOAD_WALK,
        MOAD_DONE
    } moad_flush_state_t;
endpackage

// *** rtl/moad_dec_if.sv ***
// Interface between the request stage and the attribute decode logic.
`timescale 1ns/1ns
`default_nettype none
interface moad_dec_if;
    import moad_pkg::*;
    logic [MOAD_ATTR_W-1:0] attr;
    logic                   is_write;
    logic                   table_tag;
    logic [1:0]             table_cache;
    logic                   decrypt;
    logic                   flush_tag;
    logic                   llc_alloc;
    logic                   mlc_alloc;

    modport dec (
        input  attr,
        input  is_write,
        input  table_tag,
        input  table_cache,
        output decrypt,
        output flush_tag,
        output llc_alloc,
        output mlc_alloc
    );
    modport user (
        output attr,
        output is_write,
        output table_tag,
        output table_cache,
        input  decrypt,
        input  flush_tag,
        input  llc_alloc,
        input  mlc_alloc
    );
endinterface
`default_nettype wire

// *** rtl/moad_attr_decode.sv ***
// Combinational decode of the 4-bit memory object attribute field.
`timescale 1ns/1ns
`default_nettype none
module moad_attr_decode
    import moad_pkg::*;
(
    // Decode request and result.
    moad_dec_if.dec d
);

    // Maps a cacheability code to last-level and mid-level allocation.
    function automatic logic [1:0] moad_policy(input logic [1:0] code);
        logic [1:0] res;
        res = 2'h0;
        unique case (code)
            MOAD_CACHE_NONE: res = 2'h0;
            MOAD_CACHE_LLC:  res = 2'h2;
            MOAD_CACHE_BOTH: res = 2'h3;
            MOAD_CACHE_TABLE: res = 2'h0;
        endcase
        return res;
    endfunction

    logic [1:0] policy;

    // Decode of decrypt enable, effective tag and allocation policy.
    always_comb begin
        d.decrypt   = d.attr[MOAD_BIT_DECRYPT] & ~d.is_write;
        d.flush_tag = d.is_write & (d.attr[MOAD_BIT_TAG] | d.table_tag);
        if (d.attr[MOAD_CACHE_HI:MOAD_CACHE_LO] == MOAD_CACHE_TABLE) begin
            policy = moad_policy(d.table_cache);
        end else begin
            policy = moad_policy(d.attr[MOAD_CACHE_HI:MOAD_CACHE_LO]);
        end
        d.llc_alloc = policy[1];
        d.mlc_alloc = policy[0];
    end

endmodule
`default_nettype wire

// *** rtl/moad_decoder.sv ***
// Memory object attribute decoder with last-level tag store and flush walker.
//
// Summary of operation
// - The attribute field is four bits: bit 3 decrypt, bit 2 display flush tag, bits 1:0 cacheability.
// - A read of an object with bit 3 set is decrypted on its way back to the requester.
// - Bit 3 has no effect on writes, which proceed the same whatever its value.
// - On writes the effective display flush tag is bit 2 ORed with the translation table tag.
// - The display flush tag in bit 2 is disregarded on reads.
// - The last-level cache keeps the effective tag per line and can flush only tagged lines.
// - The mid-level cache has no selective flush and is always flushed entirely.
// - Cacheability 00 takes the allocation policy from the translation table entry.
// - Cacheability 01 allocates in neither the last-level nor the mid-level cache.
// - Cacheability 10 allocates in the last-level cache only.
// - Cacheability 11 allocates in both caches.
//
// Requests pass through one register stage; flushes are served by a walker
// over a sixteen-line tag store, and a flush asked for during a walk is dropped.
`timescale 1ns/1ns
`default_nettype none
module moad_decoder
    import moad_pkg::*;
(
    // Clock and reset.
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // Incoming request from command and state logic.
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic [MOAD_ATTR_W-1:0] req_attr,
    input  wire logic [MOAD_IDX_W-1:0]  req_line,
    input  wire logic                   table_tag,
    input  wire logic [1:0]             table_cache,
    // Request issued to the cache hierarchy.
    output logic                        out_valid,
    output logic                        out_write,
    output logic [MOAD_IDX_W-1:0]       out_line,
    output logic                        out_decrypt,
    output logic                        out_flush_tag,
    output logic                        out_llc_alloc,
    output logic                        out_mlc_alloc,
    // Flush control.
    input  wire logic                   llc_flush_req,
    input  wire logic                   llc_flush_tagged,
    input  wire logic                   mlc_flush_req,
    output logic                        flush_busy,
    output logic                        llc_evict_valid,
    output logic [MOAD_IDX_W-1:0]       llc_evict_line,
    output logic                        mlc_flush_all,
    output logic                        flush_done
);

    // The field split is purely combinational and kept in its own module, so
    // the request stage and the tag store both read one copy of the decode.
    moad_dec_if dec_bus ();

    assign dec_bus.attr        = req_attr;
    assign dec_bus.is_write    = req_write;
    assign dec_bus.table_tag   = table_tag;
    assign dec_bus.table_cache = table_cache;

    moad_attr_decode u_decode (
        .d (dec_bus.dec)
    );

    // Request stage state.
    logic                  out_valid_next;
    logic                  out_write_next;
    logic [MOAD_IDX_W-1:0] out_line_next;
    logic                  out_decrypt_next;
    logic                  out_flush_tag_next;
    logic                  out_llc_alloc_next;
    logic                  out_mlc_alloc_next;

    // Decoded fields are forced low when no request is present, so that an
    // idle cycle is never mistaken for a decrypted or allocating access.
    function automatic logic moad_gate(input logic valid, input logic field);
        return valid & field;
    endfunction

    // Request and its decoded attributes move together, so the cache
    // sees the policy in the very cycle the request is presented.
    always_comb begin
        out_valid_next     = req_valid;
        out_write_next     = req_write;
        out_line_next      = req_line;
        out_decrypt_next   = moad_gate(req_valid, dec_bus.decrypt);
        out_flush_tag_next = moad_gate(req_valid, dec_bus.flush_tag);
        out_llc_alloc_next = moad_gate(req_valid, dec_bus.llc_alloc);
        out_mlc_alloc_next = moad_gate(req_valid, dec_bus.mlc_alloc);
    end

    // Request stage registers. Reset clears the valid bit and every decoded
    // field, so the cache never sees a stale policy right after reset.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid     <= 1'b0;
            out_write     <= 1'b0;
            out_line      <= MOAD_LINE_ZERO;
            out_decrypt   <= 1'b0;
            out_flush_tag <= 1'b0;
            out_llc_alloc <= 1'b0;
            out_mlc_alloc <= 1'b0;
        end else begin
            out_valid     <= out_valid_next;
            out_write     <= out_write_next;
            out_line      <= out_line_next;
            out_decrypt   <= out_decrypt_next;
            out_flush_tag <= out_flush_tag_next;
            out_llc_alloc <= out_llc_alloc_next;
            out_mlc_alloc <= out_mlc_alloc_next;
        end
    end

    // Flush walker and tag store state.
    logic [MOAD_LINES-1:0] tag_reg;
    logic [MOAD_LINES-1:0] tag_next;
    moad_flush_state_t     state_reg;
    moad_flush_state_t     state_next;
    logic [MOAD_IDX_W-1:0] idx_reg;
    logic [MOAD_IDX_W-1:0] idx_next;
    logic                  tagged_reg;
    logic                  tagged_next;
    logic                  busy_next;
    logic                  evict_next;
    logic [MOAD_IDX_W-1:0] evict_line_next;
    logic                  mlc_all_next;
    logic                  done_next;

    // Next state of tags and of the walk. A flush request arriving while a
    // walk runs is ignored; the requester waits for flush_done first.
    // A walk visits every line in index order, one per cycle, so a flush of
    // the last-level cache takes the same time whether or not lines are
    // tagged; the requester can budget for it without polling the tags.
    always_comb begin
        tag_next        = tag_reg;
        state_next      = state_reg;
        idx_next        = idx_reg;
        tagged_next     = tagged_reg;
        evict_next      = 1'b0;
        evict_line_next = idx_reg;
        mlc_all_next    = 1'b0;
        done_next       = 1'b0;
        unique case (state_reg)
            MOAD_IDLE: begin
                // Both flushes may be asked for together; the whole mid-level
                // flush goes out at once while the last-level walk starts.
                // whole mid-level flush
                if (mlc_flush_req) begin
                    mlc_all_next = 1'b1;
                end
                if (llc_flush_req) begin
                    state_next  = MOAD_WALK;
                    idx_next    = MOAD_LINE_ZERO;
                    tagged_next = llc_flush_tagged;
                end else if (mlc_flush_req) begin
                    state_next = MOAD_DONE;
                end
            end
            MOAD_WALK: begin
                // A tagged flush leaves untagged lines in place, which keeps
                // data that is never displayed warm in the last-level cache.
                // selective tagged flush
                if (!tagged_reg || tag_reg[idx_reg]) begin
                    evict_next        = 1'b1;
                    tag_next[idx_reg] = 1'b0;
                end
                idx_next = idx_reg + 4'h1;
                if (idx_reg == MOAD_LAST_LINE) begin
                    state_next = MOAD_DONE;
                end
            end
            MOAD_DONE: begin
                // One cycle of done closes every kind of flush.
                done_next  = 1'b1;
                state_next = MOAD_IDLE;
            end
            // The fourth code of the state register is never entered; should
            // it appear, the walker returns to idle instead of locking up.
            default: begin
                state_next = MOAD_IDLE;
            end
        endcase
        // tag stored per line
        // A write landing on a line in the cycle it is evicted keeps its tag,
        // since the new data was not part of the flushed contents.
        if (req_valid && req_write && dec_bus.llc_alloc) begin
            tag_next[req_line] = dec_bus.flush_tag;
        end
        busy_next = (state_next != MOAD_IDLE);
    end

    // Flush walker and tag store registers. Every flush output is registered,
    // so it is free of decode glitches; flush_done and mlc_flush_all pulse for exactly one cycle.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tag_reg         <= '0;
            state_reg       <= MOAD_IDLE;
            idx_reg         <= MOAD_LINE_ZERO;
            tagged_reg      <= 1'b0;
            flush_busy      <= 1'b0;
            llc_evict_valid <= 1'b0;
            llc_evict_line  <= MOAD_LINE_ZERO;
            mlc_flush_all   <= 1'b0;
            flush_done      <= 1'b0;
        end else begin
            tag_reg         <= tag_next;
            state_reg       <= state_next;
            idx_reg         <= idx_next;
            tagged_reg      <= tagged_next;
            flush_busy      <= busy_next;
            llc_evict_valid <= evict_next;
            llc_evict_line  <= evict_line_next;
            mlc_flush_all   <= mlc_all_next;
            flush_done      <= done_next;
        end
    end

endmodule
`default_nettype wire

// *** tb/moad_cache_sink.sv ***
// Behavioural model of the cache side that receives flush commands.
`timescale 1ns/1ns
`default_nettype none
module moad_cache_sink
    import moad_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Flush commands and record clear.
    input  wire logic                  llc_evict_valid,
    input  wire logic [MOAD_IDX_W-1:0] llc_evict_line,
    input  wire logic                  mlc_flush_all,
    input  wire logic                  clr,
    // Record of what was flushed.
    output logic [MOAD_LINES-1:0]      evict_mask,
    output logic [3:0]                 mlc_count
);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            evict_mask <= '0;
            mlc_count  <= 4'h0;
        end else begin
            if (clr)
                evict_mask <= '0;
            else if (llc_evict_valid)
                evict_mask <= evict_mask | (16'h1 << llc_evict_line);
            if (mlc_flush_all)
                mlc_count <= mlc_count + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** tb/moad_decoder_properties.sv ***
// Concurrent checks on the attribute decoder ports.
`timescale 1ns/1ns
`default_nettype none
module moad_decoder_properties
    import moad_pkg::*;
(
    // Clock, reset and request.
    input wire logic                   clock,
    input wire logic                   sys_rst,
    input wire logic                   req_valid,
    input wire logic                   req_write,
    input wire logic [MOAD_ATTR_W-1:0] req_attr,
    input wire logic [MOAD_IDX_W-1:0]  req_line,
    input wire logic                   table_tag,
    input wire logic [1:0]             table_cache,
    // Issued request and flush side.
    input wire logic                   out_valid,
    input wire logic [MOAD_IDX_W-1:0]  out_line,
    input wire logic                   out_decrypt,
    input wire logic                   out_flush_tag,
    input wire logic                   out_llc_alloc,
    input wire logic                   out_mlc_alloc,
    input wire logic                   llc_flush_req,
    input wire logic                   mlc_flush_req,
    input wire logic                   flush_busy,
    input wire logic                   llc_evict_valid,
    input wire logic                   mlc_flush_all,
    input wire logic                   flush_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Each decoded field is tied to the request taken one edge earlier.
    a_decrypt_on_read:
        assert property (out_decrypt == $past(req_valid && req_attr[3] && !req_write)) else $error("decrypt wrong");
    a_tag_on_write:
        assert property (out_flush_tag == $past(req_valid && req_write && (req_attr[2] || table_tag)))
            else $error("flush tag wrong");
    a_issue_next_cycle:
        assert property (out_valid == $past(req_valid) && (!out_valid || out_line == $past(req_line)))
            else $error("request not issued in time");
    a_table_policy:
        assert property ($past(req_valid && req_attr[1:0] == MOAD_CACHE_TABLE) |->
            out_llc_alloc == $past(table_cache[1]) && out_mlc_alloc == $past(&table_cache))
            else $error("table policy");
    a_no_alloc:
        assert property ($past(req_attr[1:0] == MOAD_CACHE_NONE || !req_valid) |-> !out_llc_alloc && !out_mlc_alloc)
            else $error("uncached access allocated");
    a_llc_only:
        assert property ($past(req_valid && req_attr[1:0] == MOAD_CACHE_LLC) |-> out_llc_alloc && !out_mlc_alloc)
            else $error("last level only policy");
    a_both_alloc:
        assert property ($past(req_valid && req_attr[1:0] == MOAD_CACHE_BOTH) |-> out_llc_alloc && out_mlc_alloc)
            else $error("both caches policy");
    a_llc_walk_len:
        assert property (!flush_busy && llc_flush_req |=> flush_busy ##17 flush_done && !flush_busy)
            else $error("walk length wrong");
    a_mlc_whole_flush:
        assert property (!flush_busy && mlc_flush_req && !llc_flush_req |=> mlc_flush_all ##1 flush_done)
            else $error("whole flush wrong");
    a_evict_in_walk:
        assert property (llc_evict_valid |-> flush_busy && !flush_done) else $error("evict outside walk");
endmodule
bind moad_decoder moad_decoder_properties u_props (.clock, .sys_rst, .req_valid, .req_write, .req_attr,
    .req_line, .table_tag, .table_cache, .out_valid, .out_line, .out_decrypt, .out_flush_tag, .out_llc_alloc,
    .out_mlc_alloc, .llc_flush_req, .mlc_flush_req, .flush_busy, .llc_evict_valid, .mlc_flush_all, .flush_done);
`default_nettype wire

// *** tb/moad_decoder_bench.sv ***
// Self-checking bench for the memory object attribute decoder.
`timescale 1ns/1ns
`default_nettype none
module moad_decoder_bench
    import moad_pkg::*;
;
    // Design pins and bench state.
    logic                   clock, sys_rst, req_valid, req_write, table_tag, clr;
    logic                   llc_flush_req, llc_flush_tagged, mlc_flush_req, out_valid, out_write;
    logic                   out_decrypt, out_flush_tag, out_llc_alloc, out_mlc_alloc;
    logic                   flush_busy, llc_evict_valid, mlc_flush_all, flush_done;
    logic [MOAD_ATTR_W-1:0] req_attr;
    logic [MOAD_IDX_W-1:0]  req_line, out_line, llc_evict_line;
    logic [1:0]             table_cache;
    logic [MOAD_LINES-1:0]  evict_mask, tagm;
    logic [3:0]             mlc_count;
    int                     err_total, n_compared;

    moad_decoder dut (.clock, .sys_rst, .req_valid, .req_write, .req_attr, .req_line, .table_tag,
        .table_cache, .out_valid, .out_write, .out_line, .out_decrypt, .out_flush_tag, .out_llc_alloc,
        .out_mlc_alloc, .llc_flush_req, .llc_flush_tagged, .mlc_flush_req, .flush_busy, .llc_evict_valid,
        .llc_evict_line, .mlc_flush_all, .flush_done);
    moad_cache_sink sink (.clock, .sys_rst, .llc_evict_valid, .llc_evict_line, .mlc_flush_all, .clr,
        .evict_mask, .mlc_count);

    // Clock at 125 MHz.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Every attribute, direction, table tag and table code, back to back; also tracks line tags.
    task t_decode;
        logic [7:0] p, q;
        logic       qv, ll, ml, tg;
        logic [9:0] e, g;
        q  = 8'h0;
        qv = 1'b0;
        for (int i = 0; i < 258; i++) begin
            @(posedge clock);
            p = 8'(i);
            req_valid   <= i < 256;
            req_attr    <= p[3:0];
            req_write   <= p[4];
            table_tag   <= p[5];
            table_cache <= p[7:6];
            req_line    <= p[3:0] ^ p[7:4];
            #1;
            ll = q[1:0] == MOAD_CACHE_TABLE ? q[7] : q[1];
            ml = q[1:0] == MOAD_CACHE_TABLE ? &q[7:6] : &q[1:0];
            tg = q[4] & (q[2] | q[5]);
            e  = qv ? {1'b1, q[3] & ~q[4], tg, ll, ml, q[4], q[3:0] ^ q[7:4]} : 10'h0;
            g  = {out_valid, out_decrypt, out_flush_tag, out_llc_alloc, out_mlc_alloc, out_valid & out_write,
                  out_valid ? out_line : 4'h0};
            chk("decode", 16'(e), 16'(g));
            if (qv & q[4] & ll)
                tagm[q[3:0] ^ q[7:4]] = tg;
            q  = p;
            qv = i < 256;
        end
    endtask

    // One flush, with a whole flush request held while busy that must be dropped.
    task t_flush(input logic l, input logic t, input logic m);
        logic [3:0]            mp;
        logic [MOAD_LINES-1:0] exp;
        int                    k;
        mp  = mlc_count;
        exp = !l ? '0 : t ? tagm : '1;
        @(posedge clock);
        clr              <= 1'b1;
        llc_flush_req    <= l;
        llc_flush_tagged <= t;
        mlc_flush_req    <= m;
        @(posedge clock);
        clr              <= 1'b0;
        llc_flush_req    <= 1'b0;
        mlc_flush_req    <= 1'b1;
        @(posedge clock);
        mlc_flush_req    <= 1'b0;
        #1;
        k = 1;
        while (flush_done !== 1'b1 && k < 40) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k == 40) begin
            err_total++;
            conclude;
        end
        @(posedge clock);
        #1;
        chk("walk length", l ? 16'h11 : 16'h1, 16'(k));
        chk("evicted lines", exp, evict_mask);
        chk("whole flushes", 16'(mp) + 16'(m), 16'(mlc_count));
        if (l)
            tagm = '0;
    endtask

    // Reset, then the scenarios in turn.
    initial begin
        sys_rst    = 1'b1;
        {req_valid, req_write, table_tag, clr, llc_flush_req, llc_flush_tagged, mlc_flush_req} = '0;
        {req_attr, req_line, table_cache} = '0;
        err_total  = 0;
        n_compared = 0;
        tagm       = '0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        t_decode;
        t_flush(1'b1, 1'b1, 1'b1);
        t_flush(1'b1, 1'b1, 1'b0);
        t_flush(1'b1, 1'b0, 1'b0);
        t_flush(1'b0, 1'b0, 1'b1);
        conclude;
    end
endmodule
`default_nettype wire
